// ===== src/rtcx_map.vh
// Operation
// R1 - Eight read-only ID bytes at 40h-47h
// R2 - Last ID byte is CRC of seven
// R3 - Century count follows binary/BCD data format
// R4 - Qualified write strobe rising edge bumps counter
// R5 - Write counter read-only, wraps after 256
// R6 - 2048-byte RAM reached only indirectly
// R7 - Host selects bank one before access
// R8 - Address from low byte plus three bits
// R9 - Data port reads/writes addressed RAM byte
// R10 - Burst bumps address on port strobe edge
// R11 - Aux battery enable gates unpowered functions
// R12 - Unpowered request needs divider pattern 01x
// R13 - Date/time match sets wake, requests power
// R14 - Long kick low pulse sets kick flag
// R15 - Power-on timeout releases request, flag stays
// R16 - Powered-on: interrupt low, inactive bit cleared
// R17 - Host writes zero, interrupt then releases
// R18 - Powered events set flags, enabled drive interrupt
// R19 - Powered enabled events always drive request
// R20 - Inactive bit one releases power request
// R21 - Host clears flags before setting inactive
// R22 - Powered down: request follows fail select
// R23 - Flags cleared by zero, one forces
// R24 - Flag with enable clears inactive bit
// R25 - Burst address wraps top to zero
`ifndef RTCX_MAP_VH
`define RTCX_MAP_VH
// Bank one register offsets
`define RTCX_OFS_MODEL     8'h40
`define RTCX_OFS_CHECK     8'h47
`define RTCX_OFS_CENTURY   8'h48
`define RTCX_OFS_DATE_ALM  8'h49
`define RTCX_OFS_CTRL_A    8'h4A
`define RTCX_OFS_CTRL_B    8'h4B
`define RTCX_OFS_ADDR_LO   8'h50
`define RTCX_OFS_ADDR_HI   8'h51
`define RTCX_OFS_DATA      8'h53
`define RTCX_OFS_WR_COUNT  8'h5E
`define RTCX_BANK_LO       8'h40
`define RTCX_BANK_HI       8'h5F
// Control A fields
`define RTCX_A_AUXOK       7
`define RTCX_A_BURST       5
`define RTCX_A_SPARE       4
`define RTCX_A_INACT       3
`define RTCX_A_WAKE        1
`define RTCX_A_KICK        0
// Control B fields
`define RTCX_B_AUXEN       7
`define RTCX_B_PFSEL       3
`define RTCX_B_WAKEEN      1
`define RTCX_B_KICKEN      0
// Reset values
`define RTCX_CTRL_A_RST    8'h00
`define RTCX_CTRL_B_RST    8'h00
// RAM geometry
`define RTCX_RAM_AW        11
`define RTCX_RAM_TOP       11'h7FF
// Check byte polynomial (reflected form)
`define RTCX_CRC_POLY      8'h8C
// Timing
`define RTCX_CLK_NS        10
`define RTCX_KICK_PW_NS    1000
`define RTCX_KICK_CYC      ((`RTCX_KICK_PW_NS + `RTCX_CLK_NS - 1) / `RTCX_CLK_NS)
`define RTCX_POTO_US       2000
`define RTCX_POTO_CYC      ((`RTCX_POTO_US * 1000) / `RTCX_CLK_NS)
`endif

// ===== src/rtcx_top.v
`timescale 1ns/1ps
`include "rtcx_map.vh"
module rtcx_top #(
   parameter [7:0]  MODEL_ID  = 8'h5A,            // Arbitrary value
   parameter [47:0] UNIQUE_ID = 48'h0123456789AB, // Arbitrary value
   parameter        POTO_CYC  = `RTCX_POTO_CYC,   // Power-on timeout cycles
   parameter        KICK_CYC  = `RTCX_KICK_CYC    // Kick low width cycles
) (
   input  wire        clk_sys_i,            // System clock
   input  wire        rstn_i,               // Async reset, active low
   input  wire [7:0]  ad_i,                 // Muxed address/data in
   output reg  [7:0]  ad_o,                 // Read data out
   output reg         ad_oe_n_o,            // Low while driving bus
   input  wire        ale_i,                // Address latch enable
   input  wire        rd_n_i,               // Read strobe
   input  wire        wr_n_i,               // Write strobe
   input  wire        cs_n_i,               // Chip select
   input  wire        bank_select_bit_i,    // Bank one selected
   input  wire        divider_ctrl_mid_i,   // Divider control middle bit
   input  wire        divider_ctrl_high_i,  // Divider control high bit
   input  wire        data_format_bit_i,    // One: binary, zero: BCD
   input  wire        year_rollover_i,      // Pulse at year 99 to 00
   input  wire        internal_power_good_i,// Main supply present
   input  wire        aux_battery_input_i,  // Aux battery present
   input  wire        kick_input_n_i,       // Kick input, active low
   input  wire [7:0]  cur_date_i,           // Current day of month
   input  wire [23:0] cur_hms_i,            // Current hour/min/sec
   input  wire [23:0] alarm_hms_i,          // Hour/min/sec alarm bytes
   input  wire        other_irq_i,          // Other interrupt pending
   output reg         power_request_n_o,    // Request pin level, always 0
   output reg         power_request_oe_n_o, // Low while request asserted
   output reg         irq_n_o,              // Interrupt pin level, always 0
   output reg         irq_oe_n_o            // Low while interrupt asserted
);

   // Power sequencing states
   localparam [2:0] ST_ON   = 3'b001;       // Main supply present
   localparam [2:0] ST_OFF  = 3'b010;       // Powered down, monitoring
   localparam [2:0] ST_WAIT = 3'b100;       // Request out, awaiting supply

   // Check byte over model and unique bytes, LSB first
   function [7:0] crc_calc;
      input [55:0] data;
      integer      i;
      reg   [7:0]  c;
      begin
         c = 8'h00;
         for (i = 0; i < 56; i = i + 1) begin
            if (c[0] ^ data[i]) begin
               c = (c >> 1) ^ `RTCX_CRC_POLY;
            end else begin
               c = c >> 1;
            end
         end
         crc_calc = c;
      end
   endfunction

   // Century increment in either number format
   function [7:0] cent_inc;
      input [7:0] v;
      input       bin;
      begin
         if (bin) begin
            cent_inc = v + 8'h01;
         end else if (v[3:0] != 4'h9) begin
            cent_inc = v + 8'h01;
         end else if (v[7:4] != 4'h9) begin
            cent_inc = {v[7:4] + 4'h1, 4'h0};
         end else begin
            cent_inc = 8'h00;
         end
      end
   endfunction

   // ID block; first model byte sits in the lowest bits
   wire [55:0] id_body  = {UNIQUE_ID[7:0], UNIQUE_ID[15:8], UNIQUE_ID[23:16],
                           UNIQUE_ID[31:24], UNIQUE_ID[39:32], UNIQUE_ID[47:40],
                           MODEL_ID};
   wire [7:0]  id_check = crc_calc(id_body);
   wire [7:0]  id_byte [0:7];               // Eight ID locations
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_id
         assign id_byte[g] = id_body[8*g+7:8*g];
      end
   endgenerate
   // R2 check byte
   assign id_byte[7] = id_check;

   // Bus sampling state
   reg  [7:0]  addr_r;                      // Latched register address
   reg         ale_q_r;                     // Previous ALE
   reg         rd_q_r;                      // Previous read strobe
   reg         wr_q_r;                      // Previous write strobe
   reg         cs_q_r;                      // Chip select during strobe
   reg  [7:0]  wdata_r;                     // Data seen while write low
   reg  [7:0]  ad_nxt;                      // Next read data

   // Registers
   reg  [7:0]  century_r;                   // Century count
   reg  [7:0]  date_alm_r;                  // Date alarm
   reg  [7:0]  ctrl_a_r;                    // Control/status A
   reg  [7:0]  ctrl_b_r;                    // Control B
   reg  [7:0]  addr_lo_r;                   // RAM address low byte
   reg  [2:0]  addr_hi_r;                   // RAM address top bits
   reg  [7:0]  wr_count_r;                  // Write event counter
   reg  [7:0]  xram [0:2047];               // Extended RAM, no reset

   // Power and event state
   reg  [2:0]  st_r;                        // Sequencer state
   reg  [2:0]  st_nxt;
   reg  [31:0] poto_cnt_r;                  // Timeout counter
   reg         timed_out_r;                 // Request dropped by timeout
   reg  [15:0] kick_cnt_r;                  // Kick low width counter
   reg         kick_seen_r;                 // Pulse already counted
   reg         match_q_r;                   // Previous match level

   wire ours    = bank_select_bit_i && addr_r >= `RTCX_BANK_LO
                  && addr_r <= `RTCX_BANK_HI;
   // R8 address formed
   wire [10:0] xaddr = {addr_hi_r, addr_lo_r};
   wire ale_fall = ale_q_r && !ale_i;
   wire wr_rise  = !wr_q_r && wr_n_i && cs_q_r;
   wire rd_rise  = !rd_q_r && rd_n_i && cs_q_r;
   wire wr_ours  = wr_rise && ours;
   // R7 bank one only for port strobes
   wire port_hit = ours && addr_r == `RTCX_OFS_DATA;

   wire pwr_on   = internal_power_good_i;
   wire burst_en = ctrl_a_r[`RTCX_A_BURST];
   wire inact    = ctrl_a_r[`RTCX_A_INACT];
   wire wake_f   = ctrl_a_r[`RTCX_A_WAKE];
   wire kick_f   = ctrl_a_r[`RTCX_A_KICK];
   wire wake_en  = ctrl_b_r[`RTCX_B_WAKEEN];
   wire kick_en  = ctrl_b_r[`RTCX_B_KICKEN];
   // R12 divider pattern 01x
   wire div_ok   = !divider_ctrl_high_i && divider_ctrl_mid_i;
   // R11 aux battery gate
   wire unpw_ok  = ctrl_b_r[`RTCX_B_AUXEN] && aux_battery_input_i && div_ok;

   // R13 full date and time compare
   wire match    = (cur_date_i == date_alm_r) && (cur_hms_i == alarm_hms_i);
   wire match_ev = match && !match_q_r;
   // R14 kick low for minimum width
   wire kick_ev  = !kick_input_n_i && !kick_seen_r
                   && kick_cnt_r == KICK_CYC[15:0] - 16'h0001;
   // Powered: every event sets its flag; unpowered: only enabled, gated ones
   wire wake_set = match_ev && (pwr_on || (wake_en && unpw_ok));
   wire kick_set = kick_ev && (pwr_on || (kick_en && unpw_ok));
   wire trig     = (wake_set && wake_en) || (kick_set && kick_en);
   // R24 enabled flag clears inactive bit
   wire wake_req = (wake_f && wake_en) || (kick_f && kick_en);

   // Bus strobe sampling and address latch
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_r  <= 8'h00;
         ale_q_r <= 1'b0;
         rd_q_r  <= 1'b1;
         wr_q_r  <= 1'b1;
         cs_q_r  <= 1'b0;
         wdata_r <= 8'h00;
      end else begin
         ale_q_r <= ale_i;
         rd_q_r  <= rd_n_i;
         wr_q_r  <= wr_n_i;
         if (ale_fall) begin
            addr_r <= ad_i;
         end
         // Chip select remembered for the closing strobe edge
         if (!rd_n_i || !wr_n_i) begin
            cs_q_r <= !cs_n_i;
         end
         if (!wr_n_i) begin
            wdata_r <= ad_i;
         end
      end
   end

   // Read data mux; reserved locations read zero
   always @* begin
      ad_nxt = 8'h00;
      if (addr_r <= `RTCX_OFS_CHECK) begin
         // R1 ID bytes
         ad_nxt = id_byte[addr_r[2:0]];
      end else begin
         case (addr_r)
            `RTCX_OFS_CENTURY:  ad_nxt = century_r;
            `RTCX_OFS_DATE_ALM: ad_nxt = date_alm_r;
            `RTCX_OFS_CTRL_A:   ad_nxt = {aux_battery_input_i, ctrl_a_r[6:0]};
            `RTCX_OFS_CTRL_B:   ad_nxt = ctrl_b_r;
            `RTCX_OFS_ADDR_LO:  ad_nxt = addr_lo_r;
            `RTCX_OFS_ADDR_HI:  ad_nxt = {5'h00, addr_hi_r};
            // R9 data port read
            `RTCX_OFS_DATA:     ad_nxt = xram[xaddr];
            `RTCX_OFS_WR_COUNT: ad_nxt = wr_count_r;
            default:            ad_nxt = 8'h00;
         endcase
      end
   end

   // Bus drive: registered, starts at the clock edge that sees the read
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ad_o      <= 8'h00;
         ad_oe_n_o <= 1'b1;
      end else begin
         ad_o      <= ad_nxt;
         ad_oe_n_o <= !(!rd_n_i && !cs_n_i && ours);
      end
   end

   // RAM write; no reset so it maps onto a plain array
   always @(posedge clk_sys_i) begin
      // R6 indirect only
      if (wr_ours && port_hit) begin
         xram[xaddr] <= wdata_r;
      end
   end

   // Host-written registers and write counter
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         century_r  <= 8'h00;
         date_alm_r <= 8'h00;
         ctrl_b_r   <= `RTCX_CTRL_B_RST;
         addr_lo_r  <= 8'h00;
         addr_hi_r  <= 3'h0;
         wr_count_r <= 8'h00;
      end else begin
         // R4 R5 every qualified write, 8-bit wrap
         if (wr_rise) begin
            wr_count_r <= wr_count_r + 8'h01;
         end
         // R3 century follows data format
         if (wr_ours && addr_r == `RTCX_OFS_CENTURY) begin
            century_r <= wdata_r;
         end else if (year_rollover_i) begin
            century_r <= cent_inc(century_r, data_format_bit_i);
         end
         if (wr_ours && addr_r == `RTCX_OFS_DATE_ALM) begin
            date_alm_r <= wdata_r;
         end
         if (wr_ours && addr_r == `RTCX_OFS_CTRL_B) begin
            ctrl_b_r <= wdata_r;
         end
         // R10 R25 burst step, 11-bit wrap at top
         if (wr_ours && addr_r == `RTCX_OFS_ADDR_LO) begin
            addr_lo_r <= wdata_r;
         end else if (wr_ours && addr_r == `RTCX_OFS_ADDR_HI) begin
            addr_hi_r <= wdata_r[2:0];
         end else if (burst_en && port_hit && (wr_rise || rd_rise)) begin
            {addr_hi_r, addr_lo_r} <= (xaddr == `RTCX_RAM_TOP) ? 11'h000
                                      : xaddr + 11'h001;
         end
      end
   end

   // Control A; hardware set beats a host clear in the same cycle
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_a_r <= `RTCX_CTRL_A_RST;
      end else begin
         if (wr_ours && addr_r == `RTCX_OFS_CTRL_A) begin
            ctrl_a_r[`RTCX_A_BURST] <= wdata_r[`RTCX_A_BURST];
            ctrl_a_r[`RTCX_A_SPARE] <= wdata_r[`RTCX_A_SPARE];
         end
         // R23 zero clears, one forces
         ctrl_a_r[`RTCX_A_WAKE] <= wake_set
            || ((wr_ours && addr_r == `RTCX_OFS_CTRL_A) ? wdata_r[`RTCX_A_WAKE]
                                                        : wake_f);
         ctrl_a_r[`RTCX_A_KICK] <= kick_set
            || ((wr_ours && addr_r == `RTCX_OFS_CTRL_A) ? wdata_r[`RTCX_A_KICK]
                                                        : kick_f);
         // R24 R16 enabled flag clears the inactive bit, winning over a write
         if (wake_req || trig) begin
            ctrl_a_r[`RTCX_A_INACT] <= 1'b0;
         end else if (wr_ours && addr_r == `RTCX_OFS_CTRL_A) begin
            // R20 software shutdown
            ctrl_a_r[`RTCX_A_INACT] <= wdata_r[`RTCX_A_INACT];
         end
      end
   end

   // Kick width filter and match edge
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         kick_cnt_r  <= 16'h0000;
         kick_seen_r <= 1'b0;
         match_q_r   <= 1'b0;
      end else begin
         match_q_r <= match;
         if (kick_input_n_i) begin
            kick_cnt_r  <= 16'h0000;
            kick_seen_r <= 1'b0;
         end else if (kick_ev) begin
            kick_seen_r <= 1'b1;
         end else if (!kick_seen_r) begin
            kick_cnt_r <= kick_cnt_r + 16'h0001;
         end
      end
   end

   // Sequencer next state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_ON: begin
            if (!pwr_on) begin
               st_nxt = ST_OFF;
            end
         end
         ST_OFF: begin
            if (pwr_on) begin
               st_nxt = ST_ON;
            end else if (trig) begin
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // R15 timeout drops back to monitoring
            if (pwr_on) begin
               st_nxt = ST_ON;
            end else if (poto_cnt_r == POTO_CYC - 1) begin
               st_nxt = ST_OFF;
            end
         end
         default: st_nxt = ST_ON;
      endcase
   end

   // Sequencer state, timeout counter and timeout latch
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r        <= ST_ON;
         poto_cnt_r  <= 32'h00000000;
         timed_out_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_r == ST_WAIT) begin
            poto_cnt_r <= poto_cnt_r + 32'h00000001;
         end else begin
            poto_cnt_r <= 32'h00000000;
         end
         // R15 flag stays set, request stays released
         if (pwr_on || trig) begin
            timed_out_r <= 1'b0;
         end else if (st_r == ST_WAIT && st_nxt == ST_OFF) begin
            timed_out_r <= 1'b1;
         end
      end
   end

   // Open-drain pins; levels fixed low, enables carry the state
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_request_n_o    <= 1'b0;
         power_request_oe_n_o <= 1'b1;
         irq_n_o              <= 1'b0;
         irq_oe_n_o           <= 1'b1;
      end else begin
         power_request_n_o <= 1'b0;
         irq_n_o           <= 1'b0;
         if (st_nxt == ST_ON) begin
            // R19 R20 powered: inactive bit governs, enabled events clear it
            power_request_oe_n_o <= inact && !trig && !wake_req;
            // R16 R17 R18 interrupt from enabled flags or others
            irq_oe_n_o <= !(wake_req || other_irq_i);
         end else if (st_nxt == ST_WAIT) begin
            // R13 R14 request while waiting for supply
            power_request_oe_n_o <= 1'b0;
            irq_oe_n_o           <= 1'b1;
         end else begin
            // R22 powered down: fail select keeps request
            power_request_oe_n_o <= !(ctrl_b_r[`RTCX_B_PFSEL] && !inact
                                      && !timed_out_r);
            irq_oe_n_o           <= 1'b1;
         end
      end
   end

endmodule

// ===== testbench/rtcx_host_model.sv
`timescale 1ns/1ps
module rtcx_host_model (
   input  wire       clk_i,  // Bus clock
   input  wire [7:0] ad_i,   // Resolved bus
   output reg  [7:0] ad_o,   // Host bus value
   output reg        ale_o,  // Address latch
   output reg        rd_n_o, // Read strobe
   output reg        wr_n_o, // Write strobe
   output reg        cs_n_o  // Select
);
   // Idle bus
   initial begin
      ad_o = 8'h00;
      ale_o = 1'b0;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      cs_n_o = 1'b1;
   end
   // ALE pulse, address taken as it falls
   task automatic adr(input [7:0] a);
      @(negedge clk_i);
      ale_o = 1'b1;
      ad_o = a;
      @(negedge clk_i);
      ale_o = 1'b0;
      @(negedge clk_i);
   endtask
   // Write commits on strobe release
   task automatic wr(input [7:0] a, input [7:0] d);
      adr(a);
      ad_o = d;
      cs_n_o = 1'b0;
      wr_n_o = 1'b0;
      @(negedge clk_i);
      wr_n_o = 1'b1;
      cs_n_o = 1'b1;
      ad_o = ~d; // Released lines show no stale value
      @(negedge clk_i); // Let the commit edge pass
   endtask
   // Read, data taken one cycle after strobe
   task automatic rd(input [7:0] a, output [7:0] d);
      adr(a);
      ad_o = ~a;
      cs_n_o = 1'b0;
      rd_n_o = 1'b0;
      @(negedge clk_i);
      d = ad_i;
      rd_n_o = 1'b1;
      cs_n_o = 1'b1;
   endtask
endmodule

// ===== testbench/rtcx_top_monitor.sv
`timescale 1ns/1ps
module rtcx_top_monitor (
   input wire clk_sys_i,             // Clock
   input wire rstn_i,                // Reset
   input wire rd_n_i,                // Read strobe
   input wire wr_n_i,                // Write strobe
   input wire cs_n_i,                // Select
   input wire bank_select_bit_i,     // Bank one
   input wire divider_ctrl_mid_i,    // Divider mid
   input wire divider_ctrl_high_i,   // Divider high
   input wire internal_power_good_i, // Supply up
   input wire aux_battery_input_i,   // Aux battery
   input wire other_irq_i,           // Other source
   input wire ad_oe_n_o,             // Bus drive
   input wire power_request_n_o,     // Request level
   input wire power_request_oe_n_o,  // Request enable
   input wire irq_n_o,               // Irq level
   input wire irq_oe_n_o             // Irq enable
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // Read strobe pair active
   sequence s_rd;
      !rd_n_i && !cs_n_i;
   endsequence
   // Supply steady long enough to be powered
   sequence s_pow;
      internal_power_good_i [*3];
   endsequence
   property p_rd_cause;
      !ad_oe_n_o |-> $past(rd_n_i) == 1'b0 && $past(cs_n_i) == 1'b0;
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("bus driven without read");
   property p_rd_hold;
      s_rd ##0 !ad_oe_n_o |=> !ad_oe_n_o;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
   property p_rd_release;
      rd_n_i || cs_n_i |=> ad_oe_n_o;
   endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus kept after read");
   property p_bank0;
      !bank_select_bit_i [*2] |-> ad_oe_n_o;
   endproperty
   a_bank0: assert property (p_bank0) else $error("bus driven in bank zero");
   property p_pins;
      power_request_n_o == 1'b0 && irq_n_o == 1'b0;
   endproperty
   a_pins: assert property (p_pins) else $error("open drain level not low");
   property p_irq_off;
      !internal_power_good_i |=> irq_oe_n_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq driven unpowered");
   property p_other;
      s_pow ##0 other_irq_i |=> !irq_oe_n_o;
   endproperty
   a_other: assert property (p_other) else $error("pending irq not driven");
   // Unpowered, no write, gating off: request must stay released
   property p_gated;
      !internal_power_good_i && wr_n_i && $past(wr_n_i) && power_request_oe_n_o
      && (divider_ctrl_high_i || !divider_ctrl_mid_i || !aux_battery_input_i)
      |=> power_request_oe_n_o;
   endproperty
   a_gated: assert property (p_gated) else $error("request while gated");
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
   localparam        POTO = 20;               // Short timeout
   localparam        KICK = 3;                // Short kick width
   localparam [7:0]  MID  = 8'hA5;            // Arbitrary value
   localparam [47:0] UID  = 48'h13579BDF2468; // Arbitrary value
   reg clk_sys_i, rstn_i, bank, dmid, dhigh, dfmt, yroll, pgood, aux, kick_n, oirq; // Inputs
   reg  [7:0]  date, v, c;                    // Date, scratch
   reg  [23:0] hms, alm;                      // Time, alarm
   reg  [7:0]  idb [8];                       // Expected id
   wire [7:0]  host_ad, dut_ad, ad_bus;       // Bus
   wire        ale, rd_n, wr_n, cs_n, ad_oe_n, preq, preq_oe_n, irq, irq_oe_n; // Pins
   int         errors, checks_done, addr, cnt, bst, k, b; // Model state
   int         mem [2048];                    // Model RAM
   int unsigned seed = 68929;                 // Random state
   // Bus level: design wins while enabled
   assign ad_bus = !ad_oe_n ? dut_ad : host_ad;
   rtcx_top #(.MODEL_ID(MID), .UNIQUE_ID(UID), .POTO_CYC(POTO), .KICK_CYC(KICK)) dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ad_i(ad_bus), .ad_o(dut_ad),
      .ad_oe_n_o(ad_oe_n), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n),
      .bank_select_bit_i(bank), .divider_ctrl_mid_i(dmid), .divider_ctrl_high_i(dhigh),
      .data_format_bit_i(dfmt), .year_rollover_i(yroll), .internal_power_good_i(pgood),
      .aux_battery_input_i(aux), .kick_input_n_i(kick_n), .cur_date_i(date),
      .cur_hms_i(hms), .alarm_hms_i(alm), .other_irq_i(oirq), .power_request_n_o(preq),
      .power_request_oe_n_o(preq_oe_n), .irq_n_o(irq), .irq_oe_n_o(irq_oe_n));
   rtcx_host_model host (.clk_i(clk_sys_i), .ad_i(ad_bus), .ad_o(host_ad), .ale_o(ale),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n));
   function automatic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Century step, BCD or binary
   function automatic [7:0] inc(input [7:0] x, input bin);
      int lo, hi;
      lo = x[3:0] + 1;
      hi = x[7:4];
      if (bin) return x + 8'h01;
      if (lo == 10) begin lo = 0; hi++; end
      if (hi == 10) hi = 0;
      return 8'(hi * 16 + lo);
   endfunction
   task automatic chk(input string nm, input [7:0] s, input [7:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic pins(input e_req, input e_irq);
      cyc(2); // Pins settle one edge after their cause
      chk("req_oe", {7'h00, preq_oe_n}, {7'h00, e_req});
      chk("irq_oe", {7'h00, irq_oe_n}, {7'h00, e_irq});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // Write plus model update
   task automatic w(input [7:0] a, input [7:0] d);
      host.wr(a, d);
      cnt = (cnt + 1) % 256;
      if (a == 8'h50) addr = (addr & 32'h700) | d;
      if (a == 8'h51) addr = (addr & 32'hFF) | ((d & 7) << 8);
      if (a == 8'h4A) bst = d[5];
      if (a == 8'h53) begin
         mem[addr] = d;
         if (bst) addr = (addr + 1) % 2048;
      end
   endtask
   task automatic r(input [7:0] a, input [7:0] e, input string nm);
      host.rd(a, v);
      if (a == 8'h53 && bst) addr = (addr + 1) % 2048;
      chk(nm, v, e);
   endtask
   task automatic kick(input int n);
      kick_n = 1'b0;
      cyc(n);
      kick_n = 1'b1;
      cyc(3);
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard, well past the expected run
   initial begin
      #300000;
      errors++;
      wrap_up();
   end
   initial begin
      {rstn_i, dfmt, yroll, dhigh, oirq} = 5'b0;
      {bank, dmid, pgood, aux, kick_n} = 5'b11111;
      {errors, checks_done, addr, cnt, bst} = 0;
      date = 8'h01;
      alm = {rnd(), rnd(), rnd()};
      hms = ~alm;
      cyc(20);
      rstn_i = 1'b1;
      c = 8'h00;
      for (k = 0; k < 7; k++) begin
         idb[k] = (k == 0) ? MID : UID[(55 - 8 * k) -: 8];
         for (b = 0; b < 8; b++) c = (c >> 1) ^ ((c[0] ^ idb[k][b]) ? 8'h8C : 8'h00);
      end
      idb[7] = c;
      for (k = 0; k < 8; k++) r(8'h40 + k[7:0], idb[k], "id_byte");
      w(8'h40, ~idb[0]);
      w(8'h5E, 8'h00);
      w(8'h4C, 8'hFF);
      r(8'h40, idb[0], "id_ro");
      r(8'h4C, 8'h00, "reserved");
      r(8'h5E, cnt[7:0], "wr_count");
      for (k = 0; k < 255; k++) w(8'h4C, rnd());
      r(8'h5E, cnt[7:0], "wr_wrap");
      bank = 1'b0;
      host.rd(8'h53, v);
      chk("bank_zero", v, 8'hAC);
      bank = 1'b1;
      $display("Test registers done");
      w(8'h4A, 8'h20);
      w(8'h50, 8'hFE);
      w(8'h51, 8'hFF);
      r(8'h51, 8'h07, "addr_hi");
      for (k = 0; k < 3; k++) w(8'h53, rnd());
      w(8'h50, 8'hFE);
      w(8'h51, 8'h07);
      for (k = 0; k < 3; k++) r(8'h53, mem[addr][7:0], "burst");
      w(8'h4A, 8'h00);
      w(8'h50, 8'h23);
      w(8'h51, 8'h01);
      w(8'h53, rnd());
      for (k = 0; k < 2; k++) r(8'h53, mem[addr][7:0], "ram");
      $display("Test ram done");
      for (k = 0; k < 3; k++) begin
         c = (k == 0) ? 8'h99 : (k == 1) ? 8'h19 : 8'h3F;
         dfmt = (k == 2);
         w(8'h48, c);
         yroll = 1'b1;
         cyc(1);
         yroll = 1'b0;
         r(8'h48, inc(c, dfmt), "century");
      end
      $display("Test century done");
      w(8'h4B, 8'h02);
      w(8'h49, 8'h15);
      w(8'h4A, 8'h08);
      pins(1'b1, 1'b1);
      date = 8'h15;
      hms = alm;
      cyc(3);
      pins(1'b0, 1'b0);
      r(8'h4A, 8'h82, "ctrl_a");
      w(8'h4A, 8'h00);
      hms = ~alm;
      cyc(2);
      pins(1'b0, 1'b1);
      oirq = 1'b1;
      cyc(2);
      pins(1'b0, 1'b0);
      oirq = 1'b0;
      w(8'h4B, 8'h01);
      w(8'h4A, 8'h09);
      r(8'h4A, 8'h81, "force");
      w(8'h4A, 8'h00); // flags cleared first
      w(8'h4A, 8'h08);
      cyc(2);
      pins(1'b1, 1'b1);
      $display("Test powered done");
      w(8'h4B, 8'h81);
      pgood = 1'b0;
      kick(KICK - 1);
      pins(1'b1, 1'b1);
      kick(KICK);
      pins(1'b0, 1'b1);
      cyc(POTO + 5);
      pins(1'b1, 1'b1);
      dhigh = 1'b1;
      kick(KICK + 2);
      pins(1'b1, 1'b1);
      dhigh = 1'b0;
      aux = 1'b0;
      kick(KICK + 2);
      pins(1'b1, 1'b1);
      aux = 1'b1;
      pgood = 1'b1;
      cyc(3);
      r(8'h4A, 8'h81, "flag_kept");
      w(8'h4B, 8'h82);
      w(8'h49, 8'h16);
      w(8'h4A, 8'h08);
      pgood = 1'b0;
      cyc(2);
      date = 8'h16;
      hms = alm;
      cyc(3);
      pins(1'b0, 1'b1);
      pgood = 1'b1;
      cyc(3);
      pins(1'b0, 1'b0);
      r(8'h4A, 8'h82, "power_on");
      w(8'h4A, 8'h00);
      hms = ~alm;
      w(8'h4B, 8'h08);
      pgood = 1'b0;
      cyc(3);
      pins(1'b0, 1'b1);
      pgood = 1'b1;
      w(8'h4B, 8'h00);
      pgood = 1'b0;
      cyc(3);
      pins(1'b1, 1'b1);
      pgood = 1'b1;
      $display("Test unpowered done");
      wrap_up();
   end
endmodule
bind rtcx_top rtcx_top_monitor mon (.*);
